// ---- rtl/ptd_diag_regs.sv ----
// ptd_diag_regs: paged test and diagnostic registers behind an AXI4-Lite slave
// assumes frame-end and crc-error strobes come from logic on core_clk_in
module ptd_diag_regs
  import ptd_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  output logic [1:0]             s_axi_bresp_out,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  input  wire logic              rx_frame_end_in,
  input  wire logic              rx_crc_err_in,
  output logic                   force_gig_out,
  output logic                   tx_class_a_out,
  output logic                   stub_loop_out,
  output logic                   crc_check_en_out,
  output logic [2:0]             pu_imp_code_out,
  output logic [2:0]             pd_imp_code_out,
  output logic                   next_off_out,
  output logic [7:0]             gen_data_out,
  output logic                   gen_valid_out,
  output logic                   gen_last_out,
  output logic                   gen_err_out,
  output logic                   irq_out
);
  logic [ADDR_W-1:0] aw_addr;
  logic [15:0]       w_data;
  logic [1:0]        w_strb;
  logic              do_write;
  logic [15:0]       page_val;
  logic [15:0]       merged;
  logic              wr_page;
  logic [4:0]        page_sel;
  logic              force_gig;
  logic              tx_class_a;
  logic              stub_loop;
  logic              crc_en;
  logic [2:0]        pu_imp;
  logic [2:0]        pd_imp;
  logic              gen_en;
  logic              gen_pat;
  logic              gen_len;
  logic              gen_err;
  logic [3:0]        misc_rsvd_hi;
  logic              misc_rsvd1;
  logic              next_off;
  logic [7:0]        frame_cnt;
  logic [7:0]        crc_err_cnt;
  logic              frame_inc;
  logic              crc_inc;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [31:0]       rd_word;
  logic              rd_bad;
  logic              wr_bad;

  ptd_gen_if gen_bus ();

  ptd_pkt_gen u_gen (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .g           (gen_bus)
  );

  assign gen_bus.en            = gen_en;
  assign gen_bus.pattern_fixed = gen_pat;
  assign gen_bus.long_len      = gen_len;
  assign gen_bus.err_ins       = gen_err;
  assign gen_data_out          = gen_bus.data;
  assign gen_valid_out         = gen_bus.valid;
  assign gen_last_out          = gen_bus.last;
  assign gen_err_out           = gen_bus.err;

  // control outputs are the field flops themselves
  assign force_gig_out    = force_gig;
  assign tx_class_a_out   = tx_class_a;
  assign stub_loop_out    = stub_loop;
  assign crc_check_en_out = crc_en;
  assign pu_imp_code_out  = pu_imp;
  assign pd_imp_code_out  = pd_imp;
  assign next_off_out     = next_off;

  // byte-lane merge; only lanes 0 and 1 carry page data
  function automatic logic [15:0] ptd_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    page_val = '0;
    unique case (page_sel)
      PAGE_FORCE_GIG:  page_val[FG_BIT] = force_gig;
      PAGE_TX_CLASS:   page_val[TXC_BIT] = tx_class_a;
      PAGE_CRC_RESULT: page_val = {frame_cnt, crc_err_cnt};
      PAGE_TEST_EN: begin
        page_val[TE_CRC_BIT]  = crc_en;
        page_val[TE_LOOP_BIT] = stub_loop;
      end
      PAGE_MISC: begin
        page_val[MISC_RSVD_LSB +: 4] = misc_rsvd_hi;
        page_val[MISC_PU_LSB +: 3]   = pu_imp;
        page_val[MISC_PD_LSB +: 3]   = pd_imp;
        page_val[MISC_GEN_BIT]       = gen_en;
        page_val[MISC_PAT_BIT]       = gen_pat;
        page_val[MISC_LEN_BIT]       = gen_len;
        page_val[MISC_ERR_BIT]       = gen_err;
        page_val[MISC_RSV1_BIT]      = misc_rsvd1;
        page_val[MISC_NEXT_BIT]      = next_off;
      end
      default: page_val = '0;
    endcase
  end

  // write happens once address and data are both held and no response pends
  assign do_write = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  assign wr_page  = do_write && (aw_addr == ADDR_PAGE_DATA);
  assign merged   = ptd_merge(page_val, w_data, w_strb);
  assign wr_bad   = !(aw_addr == ADDR_PAGE_SEL || aw_addr == ADDR_PAGE_DATA ||
                      aw_addr == ADDR_RSVD || aw_addr == ADDR_IRQ_STAT ||
                      aw_addr == ADDR_IRQ_MASK);

  // write address channel, taken independently of data
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_awready_out <= 1'b1;
      aw_addr           <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_axi_awready_out <= 1'b0;
      aw_addr           <= s_axi_awaddr_in;
    end else if (do_write) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_wready_out <= 1'b1;
      w_data           <= '0;
      w_strb           <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_axi_wready_out <= 1'b0;
      w_data           <= s_axi_wdata_in[15:0];
      w_strb           <= s_axi_wstrb_in[1:0];
    end else if (do_write) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  // write response; unmapped addresses answer slave error
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // read mux; reserved register 31 reads zero
  always_comb begin
    rd_word = '0;
    rd_bad  = 1'b0;
    unique case (s_axi_araddr_in)
      ADDR_PAGE_SEL:  rd_word[4:0] = page_sel;
      ADDR_PAGE_DATA: rd_word[15:0] = page_val;
      ADDR_RSVD:      rd_word = '0;
      ADDR_IRQ_STAT:  rd_word[IRQ_W-1:0] = irq_stat;
      ADDR_IRQ_MASK:  rd_word[IRQ_W-1:0] = irq_mask;
      default:        rd_bad = 1'b1;
    endcase
  end

  // read channel, data one edge after the address is taken
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_word;
      s_axi_rresp_out   <= rd_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
    end
  end

  // page selector, low five bits only
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      page_sel <= PAGE_RST;
    end else if (do_write && aw_addr == ADDR_PAGE_SEL && w_strb[0]) begin
      page_sel <= w_data[4:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      force_gig <= 1'b0;
    end else if (wr_page && page_sel == PAGE_FORCE_GIG) begin
      force_gig <= merged[FG_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_class_a <= 1'b0;
    end else if (wr_page && page_sel == PAGE_TX_CLASS) begin
      tx_class_a <= merged[TXC_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crc_en    <= 1'b0;
      stub_loop <= 1'b0;
    end else if (wr_page && page_sel == PAGE_TEST_EN) begin
      crc_en    <= merged[TE_CRC_BIT];
      stub_loop <= merged[TE_LOOP_BIT];
    end
  end

  // misc page; reserved fields are stored so read-modify-write round-trips
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      misc_rsvd_hi <= MISC_RSVD_RST;
      pu_imp       <= IMP_RST;
      pd_imp       <= IMP_RST;
      gen_en       <= 1'b0;
      gen_pat      <= 1'b0;
      gen_len      <= 1'b0;
      gen_err      <= 1'b0;
      misc_rsvd1   <= 1'b0;
      next_off     <= 1'b0;
    end else if (wr_page && page_sel == PAGE_MISC) begin
      misc_rsvd_hi <= merged[MISC_RSVD_LSB +: 4];
      pu_imp       <= merged[MISC_PU_LSB +: 3];
      pd_imp       <= merged[MISC_PD_LSB +: 3];
      gen_en       <= merged[MISC_GEN_BIT];
      gen_pat      <= merged[MISC_PAT_BIT];
      gen_len      <= merged[MISC_LEN_BIT];
      gen_err      <= merged[MISC_ERR_BIT];
      misc_rsvd1   <= merged[MISC_RSV1_BIT];
      next_off     <= merged[MISC_NEXT_BIT];
    end
  end

  // counting only while the checker is on
  assign frame_inc = crc_en && rx_frame_end_in && (frame_cnt != COUNT_MAX);
  assign crc_inc   = crc_en && rx_frame_end_in && rx_crc_err_in && (crc_err_cnt != COUNT_MAX);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_cnt <= '0;
    end else if (!crc_en) begin
      frame_cnt <= '0;
    end else if (frame_inc) begin
      frame_cnt <= frame_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crc_err_cnt <= '0;
    end else if (!crc_en) begin
      crc_err_cnt <= '0;
    end else if (crc_inc) begin
      crc_err_cnt <= crc_err_cnt + 1'b1;
    end
  end

  // interrupt events; a counter reaching all ones flags saturation
  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_FRAME] = frame_inc;
    irq_set[IRQ_CRC]   = crc_inc;
    irq_set[IRQ_SAT]   = (frame_inc && frame_cnt == COUNT_MAX - 1'b1) ||
                         (crc_inc && crc_err_cnt == COUNT_MAX - 1'b1);
    irq_set[IRQ_PKT]   = gen_bus.done;
  end

  assign irq_clr = (do_write && aw_addr == ADDR_IRQ_STAT && w_strb[0]) ?
                   w_data[IRQ_W-1:0] : '0;

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  // interrupt mask, one enables the bit
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask <= '0;
    end else if (do_write && aw_addr == ADDR_IRQ_MASK && w_strb[0]) begin
      irq_mask <= w_data[IRQ_W-1:0];
    end
  end

  // registered level; lags status by one clock
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat & irq_mask);
    end
  end
endmodule

// ---- rtl/ptd_pkg.sv ----
// ptd_pkg: constants shared by the paged test and diagnostic register block
// assumes a 32-bit AXI4-Lite master and 16-bit page registers in the low lanes
package ptd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned LEN_W  = 11;
  localparam int unsigned IRQ_W  = 4;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] REG_PAGE_SEL_IDX  = 8'h1D;
  localparam logic [7:0] REG_PAGE_DATA_IDX = 8'h1E;
  localparam logic [7:0] REG_RSVD_IDX      = 8'h1F;
  localparam logic [7:0] REG_IRQ_STAT_IDX  = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK_IDX  = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_PAGE_SEL  = ADDR_W'(REG_PAGE_SEL_IDX * 4);
  localparam logic [ADDR_W-1:0] ADDR_PAGE_DATA = ADDR_W'(REG_PAGE_DATA_IDX * 4);
  localparam logic [ADDR_W-1:0] ADDR_RSVD      = ADDR_W'(REG_RSVD_IDX * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = ADDR_W'(REG_IRQ_STAT_IDX * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = ADDR_W'(REG_IRQ_MASK_IDX * 4);

  // page select codes
  localparam logic [4:0] PAGE_FORCE_GIG  = 5'h07;
  localparam logic [4:0] PAGE_TX_CLASS   = 5'h0B;
  localparam logic [4:0] PAGE_CRC_RESULT = 5'h0C;
  localparam logic [4:0] PAGE_TEST_EN    = 5'h10;
  localparam logic [4:0] PAGE_MISC       = 5'h12;
  localparam logic [4:0] PAGE_RST        = 5'h00;

  // field positions
  localparam int unsigned FG_BIT        = 3;
  localparam int unsigned TXC_BIT       = 15;
  localparam int unsigned TE_CRC_BIT    = 0;
  localparam int unsigned TE_LOOP_BIT   = 1;
  localparam int unsigned MISC_RSVD_LSB = 12;
  localparam int unsigned MISC_PU_LSB   = 9;
  localparam int unsigned MISC_PD_LSB   = 6;
  localparam int unsigned MISC_GEN_BIT  = 5;
  localparam int unsigned MISC_PAT_BIT  = 4;
  localparam int unsigned MISC_LEN_BIT  = 3;
  localparam int unsigned MISC_ERR_BIT  = 2;
  localparam int unsigned MISC_RSV1_BIT = 1;
  localparam int unsigned MISC_NEXT_BIT = 0;
  localparam int unsigned CRC_FRM_LSB   = 8;

  // reset values and the counter ceiling
  localparam logic [2:0] IMP_RST       = 3'h1;
  localparam logic [3:0] MISC_RSVD_RST = 4'h8;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;

  // interrupt bits
  localparam int unsigned IRQ_FRAME = 0;
  localparam int unsigned IRQ_CRC   = 1;
  localparam int unsigned IRQ_SAT   = 2;
  localparam int unsigned IRQ_PKT   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // packet generator
  localparam logic [LEN_W-1:0] PKT_LEN_SHORT = 11'h040;
  localparam logic [LEN_W-1:0] PKT_LEN_LONG  = 11'h5EE;
  localparam logic [7:0]       FILL_BYTE     = 8'h5A;
  localparam logic [7:0]       CORRUPT_MASK  = 8'hFF;
  localparam logic [15:0]      LFSR_SEED     = 16'hACE1;
  localparam logic [15:0]      LFSR_TAPS     = 16'hB400;
endpackage

// ---- rtl/ptd_gen_if.sv ----
// ptd_gen_if: settings into and byte stream out of the packet generator
// assumes both ends sit on the same clock
interface ptd_gen_if;
  logic       en;
  logic       pattern_fixed;
  logic       long_len;
  logic       err_ins;
  logic [7:0] data;
  logic       valid;
  logic       last;
  logic       err;
  logic       done;

  modport ctrl (output en, output pattern_fixed, output long_len, output err_ins,
                input data, input valid, input last, input err, input done);
  modport gen  (input en, input pattern_fixed, input long_len, input err_ins,
                output data, output valid, output last, output err, output done);
endinterface

// ---- rtl/ptd_pkt_gen.sv ----
// ptd_pkt_gen: built-in test packet generator, one byte per clock
// assumes the sink takes every byte; there is no back-pressure
module ptd_pkt_gen
  import ptd_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  ptd_gen_if.gen    g
);
  typedef enum logic [1:0] {PTD_IDLE, PTD_SEND, PTD_GAP} ptd_gen_state_t;

  ptd_gen_state_t   state;
  logic [LEN_W-1:0] cnt;
  logic [LEN_W-1:0] last_idx;
  logic             fixed;
  logic             corrupt;
  logic [15:0]      lfsr;
  logic             at_end;

  assign at_end = (cnt == last_idx);

  // sequencing; settings latched per packet so a change never tears a frame
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state    <= PTD_IDLE;
      cnt      <= '0;
      last_idx <= '0;
      fixed    <= 1'b0;
      corrupt  <= 1'b0;
    end else begin
      unique case (state)
        PTD_IDLE: begin
          cnt <= '0;
          if (g.en) begin
            state <= PTD_SEND;
            last_idx <= g.long_len ? PKT_LEN_LONG - 1'b1 : PKT_LEN_SHORT - 1'b1;
            fixed    <= g.pattern_fixed;
            corrupt  <= g.err_ins;
          end
        end
        PTD_SEND: begin
          cnt <= cnt + 1'b1;
          if (at_end) begin
            state <= PTD_GAP;
          end
        end
        PTD_GAP: begin
          state <= PTD_IDLE;
        end
      endcase
    end
  end

  // random payload source, steps once per sent byte
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lfsr <= LFSR_SEED;
    end else if (state == PTD_SEND) begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
    end
  end

  // registered stream outputs
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      g.valid <= 1'b0;
      g.data  <= '0;
      g.last  <= 1'b0;
      g.err   <= 1'b0;
      g.done  <= 1'b0;
    end else begin
      g.valid <= (state == PTD_SEND);
      g.last  <= (state == PTD_SEND) && at_end;
      g.done  <= (state == PTD_SEND) && at_end;
      g.err   <= (state == PTD_SEND) && at_end && corrupt;
      if (state == PTD_SEND) begin
        g.data <= (fixed ? FILL_BYTE : lfsr[7:0]) ^
                  ((at_end && corrupt) ? CORRUPT_MASK : 8'h00);
      end else begin
        g.data <= '0;
      end
    end
  end
endmodule

// ---- verification/ptd_diag_regs_props.sv ----
// ptd_diag_regs_props: port checks on bus handshakes and the packet stream
// assumes one clock domain and the active-low asynchronous reset
module ptd_diag_regs_props
  import ptd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic gen_valid_out,
  input wire logic gen_last_out,
  input wire logic gen_err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [LEN_W-1:0] n_byte;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  // bytes of the current packet so far; cleared on the last byte
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      n_byte <= '0;
    end else if (gen_valid_out) begin
      n_byte <= gen_last_out ? '0 : n_byte + 1'b1;
    end
  end

  a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer late");
  a_read_once: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read data repeated");
  a_pkt_len: assert property (gen_last_out |-> n_byte == PKT_LEN_SHORT - 1 ||
    n_byte == PKT_LEN_LONG - 1) else $error("packet length wrong");
  a_err_last: assert property (gen_err_out |-> gen_valid_out && gen_last_out)
    else $error("error flag off the last byte");
  a_pkt_gap: assert property (gen_last_out |=> !gen_valid_out [*2])
    else $error("packet gap too short");
  a_pkt_run: assert property (gen_valid_out && !gen_last_out |=> gen_valid_out)
    else $error("packet bytes not consecutive");

  c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_err_pkt: cover property (gen_err_out);
  c_long_pkt: cover property (gen_last_out && n_byte == PKT_LEN_LONG - 1);
endmodule

bind ptd_diag_regs ptd_diag_regs_props ptd_diag_regs_props_i (.*);

// ---- verification/ptd_diag_regs_test.sv ----
// ptd_diag_regs_test: self-checking bench for the paged diagnostic registers
// assumes it is the only bus master and the only source of frame strobes
module ptd_diag_regs_test
  import ptd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_in, reset_n_in, rx_frame_end_in, rx_crc_err_in, irq_out;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, force_gig_out, tx_class_a_out;
  logic        stub_loop_out, crc_check_en_out, next_off_out, gen_valid_out;
  logic        gen_last_out, gen_err_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, gen_data_out;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [2:0]  pu_imp_code_out, pd_imp_code_out;
  int          n_fail = 0;
  int          n_compared = 0;
  // reference payload source; starts at LFSR_SEED, steps once per generated byte
  logic [15:0] lfsr_m = LFSR_SEED;

  ptd_diag_regs ptd_diag_regs_i (.*);

  // 100 ns clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // a wait that runs out ends the run as a failure
  task automatic tmo(input int t, input int lim);
    if (t >= lim) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge core_clk_in);
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= {16'h0000, d};
    s_axi_bready_in  <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out && n < 50);
    s_axi_bready_in <= 1'b0;
    tmo(n, 50);
    chk("bresp", s_axi_bresp_out, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge core_clk_in);
    s_axi_arvalid_in <= 1'b1;
    s_axi_araddr_in  <= a;
    s_axi_rready_in  <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out && n < 50);
    s_axi_rready_in <= 1'b0;
    rv = s_axi_rdata_out;
    tmo(n, 50);
    chk("rresp", s_axi_rresp_out, e);
  endtask

  task automatic pw(input logic [4:0] p, input logic [15:0] d);
    wr(ADDR_PAGE_SEL, {11'h000, p}, RESP_OKAY);
    wr(ADDR_PAGE_DATA, d, RESP_OKAY);
  endtask

  task automatic pr(input logic [4:0] p, input string nm, input logic [15:0] exp);
    wr(ADDR_PAGE_SEL, {11'h000, p}, RESP_OKAY);
    rd(ADDR_PAGE_DATA, RESP_OKAY);
    chk(nm, rv, {16'h0000, exp});
  endtask

  // one-cycle frame strobes with a gap between them
  task automatic frames(input int k, input logic bad);
    repeat (k) begin
      @(posedge core_clk_in);
      rx_frame_end_in <= 1'b1;
      rx_crc_err_in   <= bad;
      @(posedge core_clk_in);
      rx_frame_end_in <= 1'b0;
    end
  endtask

  task automatic t_reset();
    chk("pu", pu_imp_code_out, 32'h1);
    chk("pd", pd_imp_code_out, 32'h1);
    chk("ctl", {force_gig_out, tx_class_a_out, stub_loop_out, next_off_out}, 32'h0);
    pr(PAGE_MISC, "misc", 16'h8240);
    rd(ADDR_RSVD, RESP_OKAY);
    chk("rsvd", rv, 32'h0);
    wr(8'hF0, 16'h0001, RESP_SLVERR);
    rd(8'hF0, RESP_SLVERR);
  endtask

  task automatic t_ctl();
    pw(PAGE_FORCE_GIG, 16'h0008);
    chk("force", force_gig_out, 32'h1);
    pw(PAGE_TX_CLASS, 16'h8000);
    chk("class", tx_class_a_out, 32'h1);
    pw(PAGE_TEST_EN, 16'h0002);
    chk("loop", {stub_loop_out, crc_check_en_out}, 32'h2);
  endtask

  // error frames go past 0xFF to prove saturation
  task automatic t_count();
    pw(PAGE_CRC_RESULT, 16'hFFFF);
    pw(PAGE_TEST_EN, 16'h0001);
    chk("en", crc_check_en_out, 32'h1);
    frames(3, 1'b0);
    frames(1, 1'b1);
    pr(PAGE_CRC_RESULT, "cnt", 16'h0401);
    rd(ADDR_PAGE_DATA, RESP_OKAY);
    chk("again", rv, 32'h0401);
    frames(300, 1'b1);
    pr(PAGE_CRC_RESULT, "sat", 16'hFFFF);
    pw(PAGE_TEST_EN, 16'h0000);
    frames(2, 1'b1);
    pr(PAGE_CRC_RESULT, "clr", 16'h0000);
  endtask

  // status holds frame, crc and full events; only the full one unmasked
  task automatic t_irq();
    chk("irq", irq_out, 32'h0);
    wr(ADDR_IRQ_MASK, 16'h0004, RESP_OKAY);
    @(posedge core_clk_in);
    chk("irq", irq_out, 32'h1);
    wr(ADDR_IRQ_STAT, 16'h0004, RESP_OKAY);
    @(posedge core_clk_in);
    chk("irq", irq_out, 32'h0);
    rd(ADDR_IRQ_STAT, RESP_OKAY);
    chk("stat", rv, 32'h3);
    wr(ADDR_IRQ_STAT, 16'h000F, RESP_OKAY);
  endtask

  task automatic t_misc();
    logic [15:0] v;
    for (int c = 0; c < 8; c++) begin
      v = 16'h8000 | (16'(c) << 9) | (16'(7 - c) << 6) | 16'(c & 1);
      pw(PAGE_MISC, v);
      chk("pu", pu_imp_code_out, 32'(c));
      chk("pd", pd_imp_code_out, 32'(7 - c));
      chk("next", next_off_out, 32'(c & 1));
      pr(PAGE_MISC, "misc", v);
    end
  endtask

  task automatic grab(input int len, input logic fix, input logic err);
    int n, t;
    logic [7:0] x;
    n = 0;
    t = 0;
    do begin
      @(posedge core_clk_in);
      t++;
      if (gen_valid_out) n++;
      // random packets follow the reference source, error packets invert the last byte
      x = (fix ? FILL_BYTE : lfsr_m[7:0]) ^ ((gen_last_out && err) ? CORRUPT_MASK : 8'h00);
      if (gen_valid_out) chk("byte", gen_data_out, x);
      if (gen_valid_out) lfsr_m = lfsr_m[0] ? ((lfsr_m >> 1) ^ LFSR_TAPS) : (lfsr_m >> 1);
    end while (!(gen_valid_out && gen_last_out) && t < 3000);
    tmo(t, 3000);
    chk("len", n, len);
    chk("err", gen_err_out, err);
  endtask

  // enable then disable at once: the packet in flight still completes
  task automatic t_gen();
    fork
      grab(64, 1'b1, 1'b1);
      begin
        pw(PAGE_MISC, 16'h8274);
        wr(ADDR_PAGE_DATA, 16'h8240, RESP_OKAY);
      end
    join
    rd(ADDR_IRQ_STAT, RESP_OKAY);
    chk("done", rv, 32'h8);
    fork
      grab(1518, 1'b0, 1'b0);
      begin
        pw(PAGE_MISC, 16'h8268);
        wr(ADDR_PAGE_DATA, 16'h8240, RESP_OKAY);
      end
    join
    repeat (5) @(posedge core_clk_in);
    chk("idle", gen_valid_out, 32'h0);
  endtask

  // main sequence
  initial begin
    {reset_n_in, rx_frame_end_in, rx_crc_err_in, s_axi_awvalid_in, s_axi_wvalid_in} = '0;
    {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in} = '0;
    {s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'h3;
    repeat (6) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_ctl();
    t_count();
    t_irq();
    t_misc();
    t_gen();
    print_verdict();
  end
endmodule
